// *** trap_wait_pkg.sv ***
// Purpose: shared constants for the trap, test, viterbi and wait execution unit
// Assumes: 24-bit data words, 56-bit accumulators, 8-bit register address
// Notes:   opcode patterns of trap, viterbi store and wait are local encodings
package trap_wait_pkg;

    // register map, byte addresses
    localparam logic [7:0] ADDR_STATUS_WORD = 8'h00;
    localparam logic [7:0] ADDR_EVENT       = 8'h04;
    localparam logic [7:0] ADDR_EVENT_MASK  = 8'h08;
    localparam logic [7:0] ADDR_CYCLES      = 8'h0C;
    localparam logic [7:0] ADDR_CORE_STATE  = 8'h10;

    // status word fields
    localparam int CCR_C   = 0;
    localparam int CCR_V   = 1;
    localparam int CCR_Z   = 2;
    localparam int CCR_N   = 3;
    localparam int CCR_U   = 4;
    localparam int CCR_E   = 5;
    localparam int CCR_L   = 6;
    localparam int IPL_LSB = 8;
    localparam logic [1:0]  IPL_LONG_TRAP    = 2'h3;
    localparam logic [23:0] STATUS_WORD_INIT = 24'h000300;

    // event bits
    localparam int EVT_TRAP      = 0;
    localparam int EVT_WAIT_IN   = 1;
    localparam int EVT_WAIT_OUT  = 2;
    localparam int EVT_W         = 3;
    localparam logic [2:0] EVT_MASK_INIT = 3'h0;

    // opcode patterns
    localparam logic [7:0]  TEST_MASK_LO     = 8'hF7;
    localparam logic [7:0]  TEST_MATCH_LO    = 8'h03;
    localparam int          TEST_ACC_BIT     = 3;
    localparam logic [19:0] TRAP_MATCH_HI    = 20'h00001;
    localparam logic [15:0] VITERBI_MATCH_HI = 16'h0A00;
    localparam int          VITERBI_ACC_BIT  = 1;
    localparam int          VITERBI_IMM_BIT  = 0;
    localparam logic [23:0] WAIT_OPCODE   = 24'h0000F0;

    // exception causes
    localparam logic [1:0] CAUSE_TRAP  = 2'h0;
    localparam logic [1:0] CAUSE_IRQ   = 2'h1;
    localparam logic [1:0] CAUSE_RESET = 2'h2;
    localparam logic [1:0] CAUSE_DEBUG = 2'h3;

    // core states, gray along run -> wait -> exception
    typedef enum logic [1:0] {
        ST_RUN  = 2'b00,
        ST_WAIT = 2'b01,
        ST_EXC  = 2'b11
    } core_state_t;

endpackage

// *** cycle_count_calc.sv ***
// Purpose: total clock cycles of one instruction from base and mode extras
// Assumes: extras arrive with an applicable flag; a dash means not applicable
// Notes:   purely combinational, registered by the caller
`timescale 1ns/1ps
module cycle_count_calc (
    input  wire logic [3:0] base_cycles,
    input  wire logic [3:0] pre_update_extra,
    input  wire logic       pre_update_applies,
    input  wire logic       pre_update_used,
    input  wire logic [3:0] long_absolute_extra,
    input  wire logic       long_absolute_applies,
    input  wire logic       long_absolute_used,
    input  wire logic [3:0] long_immediate_extra,
    input  wire logic       long_immediate_applies,
    input  wire logic       long_immediate_used,
    output      logic [7:0] total_cycles
);
    function automatic logic [7:0] extra(input logic [3:0] n, input logic app, input logic used);
        // a dash column adds nothing even when the mode is used
        extra = (app && used) ? {4'h0, n} : 8'h00;
    endfunction

    always_comb begin
        total_cycles = {4'h0, base_cycles}
                     + extra(pre_update_extra, pre_update_applies, pre_update_used)
                     + extra(long_absolute_extra, long_absolute_applies, long_absolute_used)
                     + extra(long_immediate_extra, long_immediate_applies, long_immediate_used);
    end
endmodule

// *** trap_test_wait_exec.sv ***
// Purpose: executes conditional trap, accumulator test, viterbi store and wait
// Assumes: instr_valid is a one-cycle pulse from the fetch stage on core_clk
// Notes:   core_clk_en gates core and memory clocks; periph_clk_en never drops
//
// Summary of operation
// - true trap condition suspends flow and starts software exception
// - taken trap with long service routine sets priority level field to 3
// - false trap condition takes no exception, execution continues
// - trap, viterbi store and wait leave condition codes untouched
// - test compares accumulator with zero, sets codes, clears overflow, stores nothing
// - test decoded by low byte 0000d011, move field above, optional extension
// - viterbi store writes accumulator bits 47..24 to X memory
// - bits 23..0 shifted left with immediate bit in, written to Y memory
// - wait gates core and memory clocks until an unmasked interrupt
// - oscillator and peripheral clocks keep running during wait
// - wait with interrupt pending services it at once, as if never waiting
// - unmasked interrupt or hardware reset ends wait and starts exception
// - break pin or debug command also ends wait
// - base count assumes full pipeline, internal fetch, no interlock, post update
// - pre-update addressing adds its per-instruction extra cycles
// - long absolute addressing adds its per-instruction extra cycles
// - long immediate addressing adds its per-instruction extra cycles
// - a not-applicable extra adds no cycles
`timescale 1ns/1ps
module trap_test_wait_exec
(
    input  wire logic        core_clk,
    input  wire logic        reset,
    // instruction stream
    input  wire logic        instr_valid,
    input  wire logic [23:0] opcode,
    input  wire logic [15:0] operand_location,
    input  wire logic [55:0] acc_a,
    input  wire logic [55:0] acc_b,
    input  wire logic        long_isr,
    input  wire logic [3:0]  base_cycles,
    input  wire logic [3:0]  pre_update_extra,
    input  wire logic        pre_update_applies,
    input  wire logic        pre_update_used,
    input  wire logic [3:0]  long_absolute_extra,
    input  wire logic        long_absolute_applies,
    input  wire logic        long_absolute_used,
    input  wire logic [3:0]  long_immediate_extra,
    input  wire logic        long_immediate_applies,
    input  wire logic        long_immediate_used,
    // wake sources
    input  wire logic        irq_pending,
    input  wire logic        hw_reset_pin,
    input  wire logic        break_request_pin,
    input  wire logic        jtag_debug_req,
    // register port
    input  wire logic [7:0]  reg_addr,
    input  wire logic [23:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output      logic [23:0] reg_rdata,
    // results
    output      logic [23:0] status_word,
    output      logic        exc_start,
    output      logic [1:0]  exc_cause,
    output      logic        xy_wr,
    output      logic [15:0] xy_addr,
    output      logic [23:0] x_wdata,
    output      logic [23:0] y_wdata,
    output      logic [7:0]  instr_cycles,
    output      logic        core_clk_en,
    output      logic        periph_clk_en,
    output      logic        irq_out
);
    import trap_wait_pkg::*;

    typedef struct packed {
        core_state_t   state;
        logic [23:0]   sw;
        logic [EVT_W-1:0] evt;
        logic [EVT_W-1:0] mask;
        logic [1:0]    rst_sync;
        logic [1:0]    brk_sync;
        logic          exc;
        logic [1:0]    cause;
        logic          wr;
        logic [15:0]   addr;
        logic [23:0]   xd;
        logic [23:0]   yd;
        logic [7:0]    cycles;
        logic [23:0]   rdata;
    } exec_state_t;

    exec_state_t cur;
    exec_state_t next_cur;
    logic [7:0]  calc_cycles;

    ////////////////////////////////////////////////////////////////////////
    function automatic logic cond_true(input logic [3:0] cond, input logic [23:0] s);
        logic c;
        logic v;
        logic z;
        logic n;
        logic u;
        logic e;
        logic l;
        logic r;
        c = s[CCR_C];
        v = s[CCR_V];
        z = s[CCR_Z];
        n = s[CCR_N];
        u = s[CCR_U];
        e = s[CCR_E];
        l = s[CCR_L];
        unique case (cond[2:0])
            3'h0: r = c;
            3'h1: r = n ^ v;
            3'h2: r = z;
            3'h3: r = n;
            3'h4: r = z | (~u & ~e);
            3'h5: r = e;
            3'h6: r = l;
            3'h7: r = z | (n ^ v);
        endcase
        // low half asks for the flag clear, high half for it set
        cond_true = cond[3] ? r : ~r;
    endfunction

    function automatic logic [23:0] test_flags(input logic [23:0] s, input logic [55:0] a);
        logic [23:0] t;
        t = s;
        t[CCR_N] = a[55];
        t[CCR_Z] = (a == 56'h0);
        t[CCR_V] = 1'b0;
        t[CCR_E] = ~((&a[55:47]) | ~(|a[55:47]));
        t[CCR_U] = ~(a[47] ^ a[46]);
        test_flags = t;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // extras added only where the mode is used and applies
    cycle_count_calc u_cycles (
        .base_cycles            (base_cycles),
        .pre_update_extra       (pre_update_extra),
        .pre_update_applies     (pre_update_applies),
        .pre_update_used        (pre_update_used),
        .long_absolute_extra    (long_absolute_extra),
        .long_absolute_applies  (long_absolute_applies),
        .long_absolute_used     (long_absolute_used),
        .long_immediate_extra   (long_immediate_extra),
        .long_immediate_applies (long_immediate_applies),
        .long_immediate_used    (long_immediate_used),
        .total_cycles           (calc_cycles)
    );

    ////////////////////////////////////////////////////////////////////////
    logic        is_test;
    logic        is_trap;
    logic        is_viterbi;
    logic        is_wait;
    logic [55:0] test_acc;
    logic [55:0] viterbi_acc;
    logic        wake;
    logic [1:0]  wake_cause;
    logic [EVT_W-1:0] evt_set;

    always_comb begin
        is_test     = ((opcode[7:0] & TEST_MASK_LO) == TEST_MATCH_LO);
        is_trap     = (opcode[23:4] == TRAP_MATCH_HI);
        is_viterbi  = (opcode[23:8] == VITERBI_MATCH_HI);
        is_wait     = (opcode == WAIT_OPCODE);
        test_acc    = opcode[TEST_ACC_BIT] ? acc_b : acc_a;
        viterbi_acc = opcode[VITERBI_ACC_BIT] ? acc_b : acc_a;
        // reset outranks interrupt, interrupt outranks debug
        wake       = cur.rst_sync[1] | irq_pending | cur.brk_sync[1] | jtag_debug_req;
        wake_cause = cur.rst_sync[1] ? CAUSE_RESET :
                     irq_pending     ? CAUSE_IRQ   : CAUSE_DEBUG;

        next_cur = cur;
        evt_set  = '0;
        next_cur.rst_sync = {cur.rst_sync[0], hw_reset_pin};
        next_cur.brk_sync = {cur.brk_sync[0], break_request_pin};
        next_cur.exc      = 1'b0;
        next_cur.wr       = 1'b0;
        next_cur.rdata    = 24'h000000;

        unique case (cur.state)
            ST_RUN: begin
                if (instr_valid) begin
                    next_cur.cycles = calc_cycles;
                    if (is_trap) begin
                        if (cond_true(opcode[3:0], cur.sw)) begin
                            next_cur.state = ST_EXC;
                            next_cur.exc   = 1'b1;
                            next_cur.cause = CAUSE_TRAP;
                            evt_set[EVT_TRAP] = 1'b1;
                            if (long_isr) begin
                                next_cur.sw[IPL_LSB+1:IPL_LSB] = IPL_LONG_TRAP;
                            end
                        end
                        // false condition: nothing happens, next word follows
                    end else if (is_viterbi) begin
                        next_cur.wr   = 1'b1;
                        next_cur.addr = operand_location;
                        next_cur.xd   = viterbi_acc[47:24];
                        next_cur.yd   = {viterbi_acc[22:0], opcode[VITERBI_IMM_BIT]};
                    end else if (is_wait) begin
                        if (irq_pending) begin
                            next_cur.state = ST_EXC;
                            next_cur.exc   = 1'b1;
                            next_cur.cause = CAUSE_IRQ;
                        end else begin
                            next_cur.state = ST_WAIT;
                            evt_set[EVT_WAIT_IN] = 1'b1;
                        end
                    end else if (is_test) begin
                        next_cur.sw = test_flags(cur.sw, test_acc);
                    end
                end
            end
            ST_WAIT: begin
                // instr_valid ignored here; only the wake check may move
                if (wake) begin
                    next_cur.state = ST_EXC;
                    next_cur.exc   = 1'b1;
                    next_cur.cause = wake_cause;
                    evt_set[EVT_WAIT_OUT] = 1'b1;
                end
            end
            ST_EXC: begin
                // exception entry handed off in one cycle; vectoring lies elsewhere
                next_cur.state = ST_RUN;
            end
            default: begin
                next_cur.state = ST_RUN;
            end
        endcase

        // register writes; a hardware event beats a same-cycle clear
        if (reg_wr) begin
            unique case (reg_addr)
                ADDR_STATUS_WORD: next_cur.sw   = reg_wdata;
                ADDR_EVENT:       next_cur.evt  = cur.evt & ~reg_wdata[EVT_W-1:0];
                ADDR_EVENT_MASK:  next_cur.mask = reg_wdata[EVT_W-1:0];
                default: ;
            endcase
        end
        next_cur.evt = next_cur.evt | evt_set;

        if (reg_rd) begin
            unique case (reg_addr)
                ADDR_STATUS_WORD: next_cur.rdata = cur.sw;
                ADDR_EVENT:       next_cur.rdata = {21'h000000, cur.evt};
                ADDR_EVENT_MASK:  next_cur.rdata = {21'h000000, cur.mask};
                ADDR_CYCLES:      next_cur.rdata = {16'h0000, cur.cycles};
                ADDR_CORE_STATE:  next_cur.rdata = {22'h000000, cur.state};
                default:          next_cur.rdata = 24'h000000;
            endcase
        end
    end

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            cur       <= '0;
            cur.state <= ST_RUN;
            cur.sw    <= STATUS_WORD_INIT;
            cur.mask  <= EVT_MASK_INIT;
        end else begin
            cur <= next_cur;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        reg_rdata     = cur.rdata;
        status_word   = cur.sw;
        exc_start     = cur.exc;
        exc_cause     = cur.cause;
        xy_wr         = cur.wr;
        xy_addr       = cur.addr;
        x_wdata       = cur.xd;
        y_wdata       = cur.yd;
        instr_cycles  = cur.cycles;
        core_clk_en   = (cur.state != ST_WAIT);
        periph_clk_en = 1'b1;
        irq_out       = |(cur.evt & cur.mask);
    end

    ////////////////////////////////////////////////////////////////////////
    // checks
    logic [55:0] past_acc;
    logic        past_imm;
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            past_acc <= 56'h0;
            past_imm <= 1'b0;
        end else begin
            past_acc <= viterbi_acc;
            past_imm <= opcode[VITERBI_IMM_BIT];
        end
    end

    chk_trap_taken: assert property (@(posedge core_clk) disable iff (reset)
        (cur.state == ST_RUN && instr_valid && is_trap && cond_true(opcode[3:0], cur.sw))
        |=> (exc_start && exc_cause == CAUSE_TRAP) ##1 (cur.state == ST_RUN))
        else $error("taken trap did not start exception");
    chk_trap_ipl: assert property (@(posedge core_clk) disable iff (reset)
        (cur.state == ST_RUN && instr_valid && is_trap && long_isr && !reg_wr
         && cond_true(opcode[3:0], cur.sw)) |=> status_word[IPL_LSB+1:IPL_LSB] == 2'h3)
        else $error("priority level not raised by long trap");
    chk_trap_false: assert property (@(posedge core_clk) disable iff (reset)
        (cur.state == ST_RUN && instr_valid && is_trap && !cond_true(opcode[3:0], cur.sw))
        |=> !exc_start && cur.state == ST_RUN)
        else $error("false trap took an exception");
    chk_codes_kept: assert property (@(posedge core_clk) disable iff (reset)
        (cur.state == ST_RUN && instr_valid && !reg_wr && (is_trap || is_viterbi || is_wait))
        |=> status_word[7:0] == $past(status_word[7:0]))
        else $error("condition codes changed");
    chk_test_flags: assert property (@(posedge core_clk) disable iff (reset)
        (cur.state == ST_RUN && instr_valid && is_test && !is_trap && !is_viterbi && !is_wait
         && !reg_wr) |=> !status_word[CCR_V] && !xy_wr
         && status_word[CCR_Z] == ($past(test_acc) == 56'h0))
        else $error("test flags wrong");
    chk_vsl_data: assert property (@(posedge core_clk) disable iff (reset)
        xy_wr |-> x_wdata == past_acc[47:24] && y_wdata == {past_acc[22:0], past_imm})
        else $error("viterbi store data wrong");
    chk_wait_gate: assert property (@(posedge core_clk) disable iff (reset)
        (cur.state == ST_RUN && instr_valid && is_wait && !is_trap && !is_viterbi && !irq_pending)
        |=> !core_clk_en && periph_clk_en)
        else $error("wait did not gate the core");
    chk_wait_pending: assert property (@(posedge core_clk) disable iff (reset)
        (cur.state == ST_RUN && instr_valid && is_wait && !is_trap && !is_viterbi && irq_pending)
        |=> exc_start && core_clk_en)
        else $error("pending interrupt not serviced at wait");
    chk_wait_wake: assert property (@(posedge core_clk) disable iff (reset)
        (cur.state == ST_WAIT && wake) |=> exc_start && core_clk_en)
        else $error("wait did not end on wake");
    chk_wait_frozen: assert property (@(posedge core_clk) disable iff (reset)
        (cur.state == ST_WAIT && !wake && !reg_wr) |=> $stable(status_word) && !xy_wr)
        else $error("state changed while gated");

    cov_trap: cover property (@(posedge core_clk) disable iff (reset)
        exc_start && exc_cause == CAUSE_TRAP);
    cov_wait_irq: cover property (@(posedge core_clk) disable iff (reset)
        cur.state == ST_WAIT ##1 exc_start && exc_cause == CAUSE_IRQ);
    cov_viterbi: cover property (@(posedge core_clk) disable iff (reset) xy_wr);
    cov_irq_out: cover property (@(posedge core_clk) disable iff (reset) irq_out);

endmodule

// *** trap_test_wait_exec_bench.sv ***
// Purpose: self-checking bench for the trap, test, viterbi store and wait unit
// Assumes: viterbi select bit set picks accumulator B, as the test d bit does
// Notes:   each scenario is its own task; one compare task counts every check
`timescale 1ns/1ps
module trap_test_wait_exec_bench;
    import trap_wait_pkg::*;

    logic        core_clk, reset, instr_valid, long_isr;
    logic [23:0] opcode, reg_wdata, reg_rdata, status_word, x_wdata, y_wdata;
    logic [15:0] operand_location, xy_addr;
    logic [55:0] acc_a, acc_b;
    logic [3:0]  base_cycles, pre_update_extra, long_absolute_extra, long_immediate_extra;
    logic        pre_update_applies, pre_update_used, long_absolute_applies, long_absolute_used;
    logic        long_immediate_applies, long_immediate_used;
    logic        irq_pending, hw_reset_pin, break_request_pin, jtag_debug_req;
    logic [7:0]  reg_addr, instr_cycles;
    logic        reg_wr, reg_rd, exc_start, xy_wr, core_clk_en, periph_clk_en, irq_out;
    logic [1:0]  exc_cause;
    logic [23:0] rd;
    int          n_mismatch, tests_run, cycle_count;

    trap_test_wait_exec u_trap_test_wait_exec (
        .core_clk, .reset, .instr_valid, .opcode, .operand_location, .acc_a, .acc_b,
        .long_isr, .base_cycles, .pre_update_extra, .pre_update_applies, .pre_update_used,
        .long_absolute_extra, .long_absolute_applies, .long_absolute_used,
        .long_immediate_extra, .long_immediate_applies, .long_immediate_used,
        .irq_pending, .hw_reset_pin, .break_request_pin, .jtag_debug_req,
        .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .status_word, .exc_start,
        .exc_cause, .xy_wr, .xy_addr, .x_wdata, .y_wdata, .instr_cycles, .core_clk_en,
        .periph_clk_en, .irq_out
    );

    ////////////////////////////////////////////////////////////////////////////////
    always #12.5 core_clk = ~core_clk;

    // ceiling well above the hundred-odd cycles the scenarios need
    always @(posedge core_clk) begin
        cycle_count <= cycle_count + 1;
        if (cycle_count == 5000) begin
            n_mismatch++;
            conclude();
        end
    end

    task automatic conclude();
        $display("checks %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    task automatic chk(input logic [55:0] seen, input logic [55:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // one-cycle instruction; returns just after the taking edge
    task automatic issue(input logic [23:0] op);
        @(posedge core_clk);
        instr_valid <= 1'b1;
        opcode      <= op;
        @(posedge core_clk);
        instr_valid <= 1'b0;
        #1;
    endtask

    task automatic reg_write(input logic [7:0] a, input logic [23:0] d);
        @(posedge core_clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_wr    <= 1'b0;
    endtask

    task automatic reg_read(input logic [7:0] a, output logic [23:0] d);
        @(posedge core_clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd   <= 1'b0;
        #1;
        d = reg_rdata;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_test();
        reg_write(ADDR_STATUS_WORD, 24'h000002);
        acc_a <= 56'h0;
        issue(24'h000003);
        chk(status_word[6:0], 7'h14);
        acc_b <= 56'hFF_800000_000000;
        issue(24'h00000B);
        chk(status_word[6:0], 7'h08);
        chk(xy_wr, 1'b0);
    endtask

    task automatic t_trap();
        reg_write(ADDR_EVENT, 24'h000007);
        reg_write(ADDR_STATUS_WORD, 24'h000001);
        long_isr <= 1'b1;
        issue({TRAP_MATCH_HI, 4'h8});
        chk(exc_start, 1'b1);
        chk(exc_cause, CAUSE_TRAP);
        chk(status_word, 24'h000301);
        issue({TRAP_MATCH_HI, 4'h0});
        chk(exc_start, 1'b0);
        chk(status_word, 24'h000301);
        acc_a <= 56'h0;
        issue(24'h000003);
        chk(status_word[2], 1'b1);
        long_isr <= 1'b0;
        reg_write(ADDR_STATUS_WORD, 24'h000001);
        issue({TRAP_MATCH_HI, 4'h8});
        chk(exc_start, 1'b1);
        chk(status_word, 24'h000001);
    endtask

    task automatic t_viterbi();
        acc_a <= 56'h00_111111_222222;
        acc_b <= 56'h12_345678_9ABCDE;
        operand_location <= 16'hBEEF;
        reg_write(ADDR_STATUS_WORD, 24'h00000D);
        issue({VITERBI_MATCH_HI, 6'h00, 1'b1, 1'b1});
        chk(xy_wr, 1'b1);
        chk(xy_addr, 16'hBEEF);
        chk(x_wdata, acc_b[47:24]);
        chk(y_wdata, {acc_b[22:0], 1'b1});
        chk(status_word, 24'h00000D);
        issue({VITERBI_MATCH_HI, 6'h00, 1'b0, 1'b0});
        chk(y_wdata, {acc_a[22:0], 1'b0});
        chk(x_wdata, acc_a[47:24]);
    endtask

    task automatic t_cycles();
        base_cycles <= 4'h2;
        {pre_update_extra, long_absolute_extra, long_immediate_extra} <= 12'h134;
        {pre_update_applies, long_absolute_applies, long_immediate_applies} <= 3'b110;
        {pre_update_used, long_absolute_used, long_immediate_used} <= 3'b101;
        issue(24'h000003);
        chk(instr_cycles, 8'h03);
        {pre_update_applies, long_absolute_applies, long_immediate_applies} <= 3'b011;
        {pre_update_used, long_absolute_used, long_immediate_used} <= 3'b111;
        issue(24'h000003);
        chk(instr_cycles, 8'h09);
        reg_read(ADDR_CYCLES, rd);
        chk(rd, 24'h000009);
    endtask

    task automatic t_irq();
        reg_write(ADDR_EVENT_MASK, 24'h000001);
        reg_read(ADDR_EVENT, rd);
        chk(rd, 24'h000001);
        chk(irq_out, 1'b1);
        reg_write(ADDR_EVENT_MASK, 24'h000006);
        #1;
        chk(irq_out, 1'b0);
        reg_write(ADDR_EVENT, 24'h000007);
        reg_read(ADDR_EVENT, rd);
        chk(rd, 24'h000000);
        reg_read(8'h3C, rd);
        chk(rd, 24'h000000);
    endtask

    // wait, try an instruction while gated, then wake from one source
    task automatic t_wake(input logic [1:0] src, input logic [1:0] cause);
        int k;
        issue(WAIT_OPCODE);
        chk(core_clk_en, 1'b0);
        chk(periph_clk_en, 1'b1);
        reg_read(ADDR_CORE_STATE, rd);
        chk(rd, 24'h000001);
        issue({VITERBI_MATCH_HI, 8'h03});
        chk(xy_wr, 1'b0);
        chk(core_clk_en, 1'b0);
        @(posedge core_clk);
        case (src)
            2'd0: irq_pending <= 1'b1;
            2'd1: hw_reset_pin <= 1'b1;
            2'd2: break_request_pin <= 1'b1;
            default: jtag_debug_req <= 1'b1;
        endcase
        k = 0;
        while (exc_start !== 1'b1 && k < 6) begin
            @(posedge core_clk);
            #1;
            k++;
        end
        chk(exc_start, 1'b1);
        chk(exc_cause, cause);
        chk(core_clk_en, 1'b1);
        {irq_pending, hw_reset_pin, break_request_pin, jtag_debug_req} <= 4'h0;
        repeat (4) @(posedge core_clk);
    endtask

    task automatic t_waits();
        reg_write(ADDR_EVENT, 24'h000007);
        reg_write(ADDR_STATUS_WORD, 24'h000005);
        t_wake(2'd0, CAUSE_IRQ);
        reg_read(ADDR_EVENT, rd);
        chk(rd, 24'h000006);
        chk(status_word, 24'h000005);
        reg_read(ADDR_STATUS_WORD, rd);
        chk(rd, 24'h000005);
        t_wake(2'd2, CAUSE_DEBUG);
        t_wake(2'd3, CAUSE_DEBUG);
        @(posedge core_clk);
        irq_pending <= 1'b1;
        issue(WAIT_OPCODE);
        chk(exc_start, 1'b1);
        chk(exc_cause, CAUSE_IRQ);
        chk(core_clk_en, 1'b1);
        irq_pending <= 1'b0;
        repeat (2) @(posedge core_clk);
        t_wake(2'd1, CAUSE_RESET);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        {core_clk, instr_valid, long_isr, reg_wr, reg_rd} = 5'h0;
        {opcode, reg_wdata, operand_location, reg_addr} = 72'h0;
        {acc_a, acc_b} = 112'h0;
        {base_cycles, pre_update_extra, long_absolute_extra, long_immediate_extra} = 16'h0;
        {pre_update_applies, pre_update_used, long_absolute_applies} = 3'h0;
        {long_absolute_used, long_immediate_applies, long_immediate_used} = 3'h0;
        {irq_pending, hw_reset_pin, break_request_pin, jtag_debug_req} = 4'h0;
        {n_mismatch, tests_run} = 0;
        reset = 1'b1;
        repeat (12) @(posedge core_clk);
        reset <= 1'b0;
        #1;
        chk(status_word, STATUS_WORD_INIT);
        chk({core_clk_en, periph_clk_en, irq_out, exc_start, xy_wr}, 5'h18);
        t_test();
        t_trap();
        t_viterbi();
        t_cycles();
        t_irq();
        t_waits();
        conclude();
    end
endmodule
